//--- core/cpoc_pkg.sv
package cpoc_pkg;
  // ---------------------------------------------------------------
  // register map on page 1
  // ---------------------------------------------------------------
  localparam logic [7:0]  CPOC_PIPE_CTRL_ADDR  = 8'h08;
  localparam logic [7:0]  CPOC_OUT_SRC_ADDR    = 8'h09;
  localparam logic [7:0]  CPOC_PAD_ADDR        = 8'h0A;
  localparam logic [2:0]  CPOC_PAGE_SEL        = 3'h1;

  localparam int          CPOC_PIPE_W          = 11;
  localparam int          CPOC_SRC_W           = 5;
  localparam int          CPOC_PAD_W           = 11;

  localparam logic [10:0] CPOC_PIPE_RESET      = 11'h1F8;
  localparam logic [4:0]  CPOC_SRC_RESET       = 5'h0A;
  localparam logic [10:0] CPOC_PAD_RESET       = 11'h488;

  // ---------------------------------------------------------------
  // pipeline control fields
  // ---------------------------------------------------------------
  localparam int CPOC_VPHASE_BIT   = 0;
  localparam int CPOC_HPHASE_BIT   = 1;
  localparam int CPOC_SHADE_BIT    = 2;
  localparam int CPOC_DEFECT_BIT   = 3;
  localparam int CPOC_APER2D_BIT   = 4;
  localparam int CPOC_MATRIX_BIT   = 5;
  localparam int CPOC_PCLK_INV_BIT = 6;
  localparam int CPOC_GAMMA_BIT    = 7;
  localparam int CPOC_DECIM_BIT    = 8;
  localparam int CPOC_MINBLANK_BIT = 9;
  localparam int CPOC_APER1D_BIT   = 10;

  localparam logic [1:0] CPOC_MINBLANK_LINES  = 2'h2;
  localparam logic [2:0] CPOC_MINBLANK_PIXELS = 3'h4;

  // ---------------------------------------------------------------
  // output source and general pin fields
  // ---------------------------------------------------------------
  localparam int CPOC_SRC_LSB  = 0;
  localparam int CPOC_GPSEL_LSB = 3;

  typedef enum logic [1:0] {
    CPOC_SRC_RAW        = 2'h0,
    CPOC_SRC_PROCESSED  = 2'h1,
    CPOC_SRC_COMPRESSED = 2'h2,
    CPOC_SRC_RESERVED   = 2'h3
  } cpoc_src_type;

  localparam logic [1:0] CPOC_GP_NORMAL = 2'h0;
  localparam logic [1:0] CPOC_GP_FLASH  = 2'h1;

  // ---------------------------------------------------------------
  // pad fields
  // ---------------------------------------------------------------
  localparam int CPOC_DSLEW_LSB  = 0;
  localparam int CPOC_GSLEW_LSB  = 4;
  localparam int CPOC_CLAMP_BIT  = 7;
  localparam int CPOC_SSLEW_LSB  = 8;
endpackage : cpoc_pkg

//--- core/cpoc_regs.sv
// Behaviour
// - bit 0 selects vertical colour-filter phase
// - bit 1 selects horizontal colour-filter phase
// - bit 2 enables lens shading, reset zero
// - bit 3 enables defect correction, reset one
// - bit 4 enables 2D sharpening, reset one
// - bit 5 zero gives identity colour matrix
// - bit 6 inverts pixel clock, all modes
// - bit 7 enables gamma, reset one
// - bit 8 enables decimator, reset one
// - bit 9: line-active two lines early, +4 pixels
// - bit 10 enables 1D aperture, reset zero
// - source field picks raw, processed or compressed
// - pin field routes flash onto general pin eleven
// - data slew field applies only in raw mode
// - clamp bit clamps pad inputs during standby
// - serial data and general pin slew codes
module cpoc_regs (
  input  wire logic                     clock_i,
  input  wire logic                     sys_rst_i,
  input  wire logic [2:0]               page_i,
  input  wire logic                     write_en_i,
  input  wire logic                     read_en_i,
  input  wire logic [7:0]               addr_i,
  input  wire logic [15:0]              wdata_i,
  input  wire logic                     standby_i,
  input  wire logic                     flash_strobe_i,
  input  wire logic                     general_pin_eleven_out_i,
  input  wire logic [2:0]               comp_slew_i,
  output logic [15:0]                   rdata_o,
  output logic                          rvalid_o,
  output logic                          vphase_red_first_o,
  output logic                          hphase_color_first_o,
  output logic                          lens_shade_en_o,
  output logic                          defect_corr_en_o,
  output logic                          aperture2d_en_o,
  output logic                          color_matrix_en_o,
  output logic                          pclk_invert_o,
  output logic                          gamma_en_o,
  output logic                          decimator_en_o,
  output logic [1:0]                    line_lead_lines_o,
  output logic [2:0]                    line_extra_pixels_o,
  output logic                          aperture1d_en_o,
  output cpoc_pkg::cpoc_src_type        out_source_o,
  output logic                          flash_on_pin11_o,
  output logic                          general_pin_eleven_o,
  output logic [2:0]                    data_pad_slew_o,
  output logic [2:0]                    gpio_slew_o,
  output logic [2:0]                    serial_data_slew_o,
  output logic                          pad_clamp_o
);
  import cpoc_pkg::*;

  // ---------------------------------------------------------------
  // register storage
  // ---------------------------------------------------------------
  logic [CPOC_PIPE_W-1:0] color_pipeline_control;
  logic [CPOC_SRC_W-1:0]  output_source_bypass;
  logic [CPOC_PAD_W-1:0]  pad_slew_and_clamp;
  logic [CPOC_PIPE_W-1:0] next_pipe;
  logic [CPOC_SRC_W-1:0]  next_src;
  logic [CPOC_PAD_W-1:0]  next_pad;
  logic                   page_ok;
  logic [1:0]             next_src_sel;
  logic [1:0]             next_gp_sel;

  // other pages alias different registers, so page one gates every access
  assign page_ok = (page_i == CPOC_PAGE_SEL);

  always_comb begin
    next_pipe = color_pipeline_control;
    next_src  = output_source_bypass;
    next_pad  = pad_slew_and_clamp;
    if (write_en_i && page_ok) begin
      case (addr_i)
        CPOC_PIPE_CTRL_ADDR: next_pipe = wdata_i[CPOC_PIPE_W-1:0];
        CPOC_OUT_SRC_ADDR:   next_src  = wdata_i[CPOC_SRC_W-1:0];
        CPOC_PAD_ADDR:       next_pad  = wdata_i[CPOC_PAD_W-1:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      color_pipeline_control <= CPOC_PIPE_RESET;
      output_source_bypass   <= CPOC_SRC_RESET;
      pad_slew_and_clamp     <= CPOC_PAD_RESET;
    end else begin
      color_pipeline_control <= next_pipe;
      output_source_bypass   <= next_src;
      pad_slew_and_clamp     <= next_pad;
    end
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      rdata_o  <= 16'h0000;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= read_en_i;
      rdata_o  <= 16'h0000;
      if (read_en_i && page_ok) begin
        case (addr_i)
          CPOC_PIPE_CTRL_ADDR: rdata_o <= {5'h00, color_pipeline_control};
          CPOC_OUT_SRC_ADDR:   rdata_o <= {11'h000, output_source_bypass};
          CPOC_PAD_ADDR:       rdata_o <= {5'h00, pad_slew_and_clamp};
          default:             rdata_o <= 16'h0000;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // pipeline stage controls
  // ---------------------------------------------------------------
  // outputs load from the next value, so a write acts at the very next edge
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      vphase_red_first_o   <= CPOC_PIPE_RESET[CPOC_VPHASE_BIT];
      hphase_color_first_o <= CPOC_PIPE_RESET[CPOC_HPHASE_BIT];
      lens_shade_en_o      <= CPOC_PIPE_RESET[CPOC_SHADE_BIT];
      defect_corr_en_o     <= CPOC_PIPE_RESET[CPOC_DEFECT_BIT];
      aperture2d_en_o      <= CPOC_PIPE_RESET[CPOC_APER2D_BIT];
      color_matrix_en_o    <= CPOC_PIPE_RESET[CPOC_MATRIX_BIT];
      pclk_invert_o        <= CPOC_PIPE_RESET[CPOC_PCLK_INV_BIT];
      gamma_en_o           <= CPOC_PIPE_RESET[CPOC_GAMMA_BIT];
      decimator_en_o       <= CPOC_PIPE_RESET[CPOC_DECIM_BIT];
      aperture1d_en_o      <= CPOC_PIPE_RESET[CPOC_APER1D_BIT];
      line_lead_lines_o    <= 2'h0;
      line_extra_pixels_o  <= 3'h0;
    end else begin
      vphase_red_first_o   <= next_pipe[CPOC_VPHASE_BIT];
      hphase_color_first_o <= next_pipe[CPOC_HPHASE_BIT];
      lens_shade_en_o      <= next_pipe[CPOC_SHADE_BIT];
      defect_corr_en_o     <= next_pipe[CPOC_DEFECT_BIT];
      aperture2d_en_o      <= next_pipe[CPOC_APER2D_BIT];
      color_matrix_en_o    <= next_pipe[CPOC_MATRIX_BIT];
      pclk_invert_o        <= next_pipe[CPOC_PCLK_INV_BIT];
      gamma_en_o           <= next_pipe[CPOC_GAMMA_BIT];
      decimator_en_o       <= next_pipe[CPOC_DECIM_BIT];
      aperture1d_en_o      <= next_pipe[CPOC_APER1D_BIT];
      line_lead_lines_o    <= next_pipe[CPOC_MINBLANK_BIT] ? CPOC_MINBLANK_LINES : 2'h0;
      line_extra_pixels_o  <= next_pipe[CPOC_MINBLANK_BIT] ? CPOC_MINBLANK_PIXELS : 3'h0;
    end
  end

  // ---------------------------------------------------------------
  // output source and general pin routing
  // ---------------------------------------------------------------
  assign next_src_sel = next_src[CPOC_SRC_LSB +: 2];
  assign next_gp_sel  = next_src[CPOC_GPSEL_LSB +: 2];

  // the reserved source code is passed on; downstream treats it as undefined
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      out_source_o         <= cpoc_src_type'(CPOC_SRC_RESET[CPOC_SRC_LSB +: 2]);
      flash_on_pin11_o     <= (CPOC_SRC_RESET[CPOC_GPSEL_LSB +: 2] == CPOC_GP_FLASH);
      general_pin_eleven_o <= 1'b0;
    end else begin
      out_source_o         <= cpoc_src_type'(next_src_sel);
      flash_on_pin11_o     <= (next_gp_sel == CPOC_GP_FLASH);
      // reserved codes fall back to the plain pin rather than a floating mux
      general_pin_eleven_o <= (next_gp_sel == CPOC_GP_FLASH) ? flash_strobe_i
                                                              : general_pin_eleven_out_i;
    end
  end

  // ---------------------------------------------------------------
  // pad slew and standby clamp
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      data_pad_slew_o    <= CPOC_PAD_RESET[CPOC_DSLEW_LSB +: 3];
      gpio_slew_o        <= CPOC_PAD_RESET[CPOC_GSLEW_LSB +: 3];
      serial_data_slew_o <= CPOC_PAD_RESET[CPOC_SSLEW_LSB +: 3];
      pad_clamp_o        <= 1'b0;
    end else begin
      data_pad_slew_o    <= (next_src_sel == CPOC_SRC_RAW) ? next_pad[CPOC_DSLEW_LSB +: 3]
                                                           : comp_slew_i;
      gpio_slew_o        <= next_pad[CPOC_GSLEW_LSB +: 3];
      serial_data_slew_o <= next_pad[CPOC_SSLEW_LSB +: 3];
      // clamping only in standby keeps live inputs readable in normal use
      pad_clamp_o        <= next_pad[CPOC_CLAMP_BIT] & standby_i;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  logic wr_pipe;
  logic wr_src;
  logic wr_pad;
  assign wr_pipe = write_en_i && page_ok && addr_i == CPOC_PIPE_CTRL_ADDR;
  assign wr_src  = write_en_i && page_ok && addr_i == CPOC_OUT_SRC_ADDR;
  assign wr_pad  = write_en_i && page_ok && addr_i == CPOC_PAD_ADDR;

  chk_shade_write: assert property (
    wr_pipe |=> lens_shade_en_o == $past(wdata_i[CPOC_SHADE_BIT]))
    else $error("lens shading enable not taken from write");

  chk_stage_hold: assert property (
    !wr_pipe |=> $stable(defect_corr_en_o) && $stable(gamma_en_o))
    else $error("stage enable moved without a write");

  chk_minblank_pair: assert property (
    (line_lead_lines_o == CPOC_MINBLANK_LINES) == (line_extra_pixels_o == CPOC_MINBLANK_PIXELS))
    else $error("minblank lead and extension disagree");

  chk_pclk_invert: assert property (
    wr_pipe ##1 !wr_pipe |=> pclk_invert_o == $past(wdata_i[CPOC_PCLK_INV_BIT], 2))
    else $error("pixel clock invert not held after write");

  chk_flash_route: assert property (
    flash_on_pin11_o && !wr_src |=> general_pin_eleven_o == $past(flash_strobe_i))
    else $error("flash strobe not on general pin eleven");

  chk_raw_slew: assert property (
    out_source_o != CPOC_SRC_RAW && !wr_src |=> data_pad_slew_o == $past(comp_slew_i))
    else $error("raw slew field used outside raw mode");

  chk_clamp_standby: assert property (
    !standby_i |=> !pad_clamp_o)
    else $error("pad clamp active outside standby");

  chk_serial_slew: assert property (
    wr_pad |=> serial_data_slew_o == $past(wdata_i[CPOC_SSLEW_LSB +: 3]))
    else $error("serial data slew not taken from write");

  chk_readback: assert property (
    wr_pipe ##1 !wr_pipe
      ##1 (read_en_i && page_ok && addr_i == CPOC_PIPE_CTRL_ADDR && !wr_pipe)
      |=> rvalid_o && rdata_o[10:0] == $past(wdata_i[10:0], 3))
    else $error("pipeline control read back wrong");

  chk_source_write: assert property (
    wr_src |=> out_source_o == cpoc_src_type'($past(wdata_i[1:0])))
    else $error("output source not taken from write");

  // ---------------------------------------------------------------
  // per-bit capture checks
  // ---------------------------------------------------------------
  // each stage bit is checked on its own so a swapped pair cannot hide
  chk_vphase_write: assert property (
    wr_pipe |=> vphase_red_first_o == $past(wdata_i[CPOC_VPHASE_BIT]))
    else $error("vertical phase not taken from write");

  chk_hphase_write: assert property (
    wr_pipe |=> hphase_color_first_o == $past(wdata_i[CPOC_HPHASE_BIT]))
    else $error("horizontal phase not taken from write");

  chk_defect_write: assert property (
    wr_pipe |=> defect_corr_en_o == $past(wdata_i[CPOC_DEFECT_BIT]))
    else $error("defect correction enable not taken from write");

  chk_aper2d_write: assert property (
    wr_pipe |=> aperture2d_en_o == $past(wdata_i[CPOC_APER2D_BIT]))
    else $error("2D aperture enable not taken from write");

  chk_matrix_write: assert property (
    wr_pipe |=> color_matrix_en_o == $past(wdata_i[CPOC_MATRIX_BIT]))
    else $error("colour matrix enable not taken from write");

  chk_gamma_write: assert property (
    wr_pipe |=> gamma_en_o == $past(wdata_i[CPOC_GAMMA_BIT]))
    else $error("gamma enable not taken from write");

  chk_decim_write: assert property (
    wr_pipe |=> decimator_en_o == $past(wdata_i[CPOC_DECIM_BIT]))
    else $error("decimator enable not taken from write");

  chk_minblank_write: assert property (
    wr_pipe |=> (line_lead_lines_o != 2'h0) == $past(wdata_i[CPOC_MINBLANK_BIT]))
    else $error("minblank lead not taken from write");

  chk_aper1d_write: assert property (
    wr_pipe |=> aperture1d_en_o == $past(wdata_i[CPOC_APER1D_BIT]))
    else $error("1D aperture enable not taken from write");

  // ---------------------------------------------------------------
  // routing, pad and access checks
  // ---------------------------------------------------------------
  chk_gp_normal: assert property (
    !flash_on_pin11_o && !wr_src |=> general_pin_eleven_o == $past(general_pin_eleven_out_i))
    else $error("plain general pin level not passed");

  chk_raw_slew_use: assert property (
    out_source_o == CPOC_SRC_RAW && !wr_src && !wr_pad
      |=> data_pad_slew_o == $past(pad_slew_and_clamp[CPOC_DSLEW_LSB +: 3]))
    else $error("raw mode slew not taken from pad field");

  chk_clamp_follow: assert property (
    standby_i && !wr_pad |=> pad_clamp_o == $past(pad_slew_and_clamp[CPOC_CLAMP_BIT]))
    else $error("pad clamp does not follow clamp bit in standby");

  chk_gpio_slew: assert property (
    wr_pad |=> gpio_slew_o == $past(wdata_i[CPOC_GSLEW_LSB +: 3]))
    else $error("general pin slew not taken from write");

  chk_page_refuse: assert property (
    write_en_i && !page_ok |=> $stable(color_pipeline_control)
      && $stable(output_source_bypass) && $stable(pad_slew_and_clamp))
    else $error("register changed by a write on another page");

  chk_read_refuse: assert property (
    read_en_i && !page_ok |=> rdata_o == 16'h0000)
    else $error("read on another page returned data");

  chk_read_pulse: assert property (
    read_en_i |=> rvalid_o)
    else $error("read valid missing after read strobe");

  chk_read_idle: assert property (
    !read_en_i |=> !rvalid_o)
    else $error("read valid without read strobe");
endmodule : cpoc_regs

//--- verification/cpoc_host_model.sv
module cpoc_host_model (
  input  wire logic        clock_i,
  input  wire logic [15:0] rdata_i,
  input  wire logic        rvalid_i,
  output logic      [2:0]  page_o,
  output logic             write_en_o,
  output logic             read_en_o,
  output logic      [7:0]  addr_o,
  output logic      [15:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import cpoc_pkg::*;
  // ------------------------------
  // host side of the register port
  // ------------------------------
  initial begin
    page_o     = CPOC_PAGE_SEL;
    write_en_o = 1'b0;
    read_en_o  = 1'b0;
    addr_o     = 8'h00;
    wdata_o    = 16'h0000;
  end
  task automatic set_page(input logic [2:0] p);
    @(posedge clock_i) #1;
    page_o = p;
  endtask : set_page
  // released lines show the inverse so a stale copy cannot pass
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock_i) #1;
    addr_o     = a;
    wdata_o    = d;
    write_en_o = 1'b1;
    @(posedge clock_i) #1;
    write_en_o = 1'b0;
    addr_o     = ~a;
    wdata_o    = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    d = 'x;
    @(posedge clock_i) #1;
    addr_o    = a;
    read_en_o = 1'b1;
    @(posedge clock_i) #1;
    read_en_o = 1'b0;
    addr_o    = ~a;
    for (int n = 0; n < 3; n++) begin
      if (rvalid_i === 1'b1) begin
        d = rdata_i;
        break;
      end
      @(posedge clock_i) #1;
    end
  endtask : rd
endmodule : cpoc_host_model

//--- verification/color_pipeline_output_ctrl_tb.sv
module color_pipeline_output_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import cpoc_pkg::*;
  // ------------------------------
  // design and host hookup
  // ------------------------------
  logic         clock_i, sys_rst_i, write_en_i, read_en_i, rvalid_o, standby_i;
  logic         flash_strobe_i, general_pin_eleven_out_i, flash_on_pin11_o, general_pin_eleven_o;
  logic [2:0]   page_i, comp_slew_i, line_extra_pixels_o, data_pad_slew_o;
  logic [2:0]   gpio_slew_o, serial_data_slew_o;
  logic [7:0]   addr_i;
  logic [15:0]  wdata_i, rdata_o;
  logic [1:0]   line_lead_lines_o;
  logic         vphase_red_first_o, hphase_color_first_o, lens_shade_en_o, pad_clamp_o;
  logic         defect_corr_en_o, aperture2d_en_o, color_matrix_en_o, pclk_invert_o;
  logic         gamma_en_o, decimator_en_o, aperture1d_en_o;
  cpoc_src_type out_source_o;
  int           errors = 0;
  int           checks = 0;
  wire logic [15:0] stage_vec = {1'b0, line_lead_lines_o, line_extra_pixels_o,
    aperture1d_en_o, decimator_en_o, gamma_en_o, pclk_invert_o, color_matrix_en_o,
    aperture2d_en_o, defect_corr_en_o, lens_shade_en_o, hphase_color_first_o,
    vphase_red_first_o};
  cpoc_regs i_dut (
    .clock_i, .sys_rst_i, .page_i, .write_en_i, .read_en_i, .addr_i, .wdata_i,
    .standby_i, .flash_strobe_i, .general_pin_eleven_out_i, .comp_slew_i, .rdata_o, .rvalid_o,
    .vphase_red_first_o, .hphase_color_first_o, .lens_shade_en_o, .defect_corr_en_o,
    .aperture2d_en_o, .color_matrix_en_o, .pclk_invert_o, .gamma_en_o,
    .decimator_en_o, .line_lead_lines_o, .line_extra_pixels_o, .aperture1d_en_o,
    .out_source_o, .flash_on_pin11_o, .general_pin_eleven_o, .data_pad_slew_o,
    .gpio_slew_o, .serial_data_slew_o, .pad_clamp_o
  );
  cpoc_host_model i_host (
    .clock_i, .rdata_i(rdata_o), .rvalid_i(rvalid_o), .page_o(page_i),
    .write_en_o(write_en_i), .read_en_o(read_en_i), .addr_o(addr_i), .wdata_o(wdata_i)
  );
  // ------------------------------
  // checks and scenarios
  // ------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] d;
    i_host.rd(a, d);
    check(d, exp);
  endtask : rd_chk
  function automatic logic [15:0] pipe_exp(input logic [10:0] v);
    return {1'b0, v[9] ? 2'h2 : 2'h0, v[9] ? 3'h4 : 3'h0, v[10], v[8:0]};
  endfunction : pipe_exp
  task automatic test_reset;
    check(stage_vec, pipe_exp(11'h1F8));
    check({9'h000, flash_on_pin11_o, serial_data_slew_o, 1'b0, out_source_o}, 16'h0062);
    rd_chk(CPOC_PIPE_CTRL_ADDR, 16'h01F8);
    rd_chk(CPOC_OUT_SRC_ADDR, 16'h000A);
    rd_chk(CPOC_PAD_ADDR, 16'h0488);
  endtask : test_reset
  task automatic test_pipe;
    logic [10:0] v;
    for (int i = 0; i < 12; i++) begin
      v = (i == 11) ? 11'h7FF : 11'h001 << i;
      i_host.wr(CPOC_PIPE_CTRL_ADDR, {5'h00, v});
      check(stage_vec, pipe_exp(v));
      rd_chk(CPOC_PIPE_CTRL_ADDR, {5'h00, v});
    end
  endtask : test_pipe
  // every source and pin code, pin levels opposite so a wrong route shows
  task automatic test_source;
    logic [3:0] c;
    for (int k = 0; k < 16; k++) begin
      c = 4'(k);
      flash_strobe_i = c[0];
      general_pin_eleven_out_i   = ~c[0];
      i_host.wr(CPOC_OUT_SRC_ADDR, {11'h000, c[3:2], 1'b0, c[1:0]});
      repeat (2) @(posedge clock_i);
      #1;
      check({9'h000, general_pin_eleven_o, flash_on_pin11_o, data_pad_slew_o, out_source_o},
        {9'h000, (c[3:2] == 2'h1) ? c[0] : ~c[0], c[3:2] == 2'h1,
        (c[1:0] == 2'h0) ? 3'h0 : 3'h5, c[1:0]});
    end
  endtask : test_source
  // standby is set before each pad write, covering all four clamp and standby pairings; clamp is cleared once standby is left
  task automatic test_pad;
    logic [10:0] v;
    i_host.wr(CPOC_OUT_SRC_ADDR, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      v = k[1] ? 11'h6A3 : 11'h533;
      standby_i = k[0];
      i_host.wr(CPOC_PAD_ADDR, {5'h00, v});
      repeat (2) @(posedge clock_i);
      #1;
      check({5'h00, serial_data_slew_o, 1'b0, gpio_slew_o, pad_clamp_o, data_pad_slew_o},
        {5'h00, v[10:8], 1'b0, v[6:4], v[7] & k[0], v[2:0]});
      rd_chk(CPOC_PAD_ADDR, {5'h00, v});
    end
    standby_i = 1'b0;
    i_host.wr(CPOC_PAD_ADDR, 16'h0433);
  endtask : test_pad
  task automatic test_refuse;
    i_host.wr(CPOC_PIPE_CTRL_ADDR, 16'h0155);
    i_host.set_page(3'h0);
    i_host.wr(CPOC_PIPE_CTRL_ADDR, 16'h02AA);
    rd_chk(CPOC_PIPE_CTRL_ADDR, 16'h0000);
    i_host.set_page(CPOC_PAGE_SEL);
    check(stage_vec, pipe_exp(11'h155));
    rd_chk(8'h0B, 16'h0000);
    @(posedge clock_i) #1;
    sys_rst_i = 1'b1;
    @(posedge clock_i) #1;
    sys_rst_i = 1'b0;
    check(stage_vec, pipe_exp(CPOC_PIPE_RESET));
    rd_chk(CPOC_PIPE_CTRL_ADDR, 16'h01F8);
  endtask : test_refuse
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop
  always #25 clock_i = ~clock_i;
  initial begin
    clock_i        = 1'b0;
    sys_rst_i      = 1'b1;
    standby_i      = 1'b0;
    flash_strobe_i = 1'b0;
    general_pin_eleven_out_i   = 1'b0;
    comp_slew_i    = 3'h5;
    repeat (2) @(posedge clock_i);
    #1;
    sys_rst_i = 1'b0;
    test_reset();
    test_pipe();
    test_source();
    test_pad();
    test_refuse();
    report_and_stop();
  end
  // the scenarios need well under a thousand cycles
  initial begin
    #100000;
    errors++;
    report_and_stop();
  end
endmodule : color_pipeline_output_ctrl_tb
